// [core/host_fifo_pkg.sv]
/*
 * Shared constants and carrier types for the host FIFO port block.
 * Assumes a byte-addressed host bus whose 32-bit words sit on aligned offsets.
 */
package host_fifo_pkg;

  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int FIFO_DEPTH = 8;

  // Aliased data blocks span 32 bytes: 8 words at 32 bits, 16 halfwords at 16 bits.
  localparam int          ALIAS_SHIFT   = 5;
  localparam logic [2:0]  RX_DATA_BLOCK = 3'h0;
  localparam logic [2:0]  TX_DATA_BLOCK = 3'h1;
  localparam logic [7:0]  RX_STS_POP    = 8'h40;
  localparam logic [7:0]  RX_STS_PEEK   = 8'h44;
  localparam logic [7:0]  TX_STS_POP    = 8'h48;
  localparam logic [7:0]  TX_STS_PEEK   = 8'h4C;
  localparam logic [7:0]  CTRL_OFS      = 8'h50;
  localparam logic [7:0]  EVENT_OFS     = 8'h54;
  localparam logic [7:0]  LATCH_OFS     = 8'h58;
  localparam logic [7:0]  LEVEL_OFS     = 8'h5C;

  localparam int CTRL_SOFT_RST_BIT = 0;
  localparam int CTRL_RX_FLUSH_BIT = 1;
  localparam int CTRL_TX_FLUSH_BIT = 2;
  localparam int CTRL_SCRATCH_LSB  = 8;
  localparam int SCRATCH_W         = 8;

  localparam int EV_TX_OVR_BIT   = 0;
  localparam int EV_RX_UNDER_BIT = 1;
  localparam int EV_STS_UNDER_BIT = 2;
  localparam int EV_W            = 3;

  localparam int LAT_HIGH_BIT = 0;
  localparam int LAT_LOW_BIT  = 1;
  localparam int DROP_LSB     = 16;
  localparam int DROP_W       = 16;

  localparam int LVL_RX_STS_LSB  = 0;
  localparam int LVL_RX_DATA_LSB = 8;
  localparam int LVL_TX_STS_LSB  = 16;
  localparam int LVL_TX_DATA_LSB = 24;

  localparam logic [SCRATCH_W-1:0] SCRATCH_RST = 8'h00;
  localparam logic [EV_W-1:0]      EVENT_RST   = 3'h0;
  localparam logic [DROP_W-1:0]    DROP_RST    = 16'h0000;
  localparam logic [DATA_W-1:0]    WORD_ZERO   = 32'h00000000;
  localparam logic [DATA_W-1:0]    MASK_LO16   = 32'h0000FFFF;
  localparam logic [DATA_W-1:0]    MASK_HI16   = 32'hFFFF0000;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } host_req_t;

endpackage

// [core/fifo_buf.sv]
/*
 * Synchronous FIFO with a registered head word and a run-time capacity limit.
 * Assumes one clock, a synchronous active-low reset and a clock enable.
 */
`timescale 1ns/100ps
module fifo_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int LVL_W = $clog2(DEPTH + 1)
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic             clear_i,
  input  wire logic [LVL_W-1:0] limit_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [LVL_W-1:0] level_o
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [LVL_W-1:0] count_q;
  logic [LVL_W-1:0] cap;
  logic             push;
  logic             pop;

  function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // A zero or oversized limit falls back to the full depth rather than wedging the path.
  assign cap = (limit_i == '0 || limit_i > LVL_W'(DEPTH)) ? LVL_W'(DEPTH) : limit_i;
  assign in_ready_o  = (count_q < cap) && !clear_i;
  assign out_valid_o = (count_q != '0);
  assign level_o     = count_q;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge sys_clk_i)
  begin
    if (ce_i && push)
    begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i || (ce_i && clear_i))
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end
    else if (ce_i)
    begin
      if (push)
      begin
        wr_ptr_q <= next_ptr(wr_ptr_q);
      end
      if (pop)
      begin
        rd_ptr_q <= next_ptr(rd_ptr_q);
      end
      case ({push, pop})
        2'b10:   count_q <= count_q + 1'b1;
        2'b01:   count_q <= count_q - 1'b1;
        default: count_q <= count_q;
      endcase
    end
  end

  // The head is kept in a register so the host sees it without a memory read delay.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      out_data_o <= '0;
    end
    else if (ce_i)
    begin
      if (push && (count_q == '0 || (count_q == LVL_W'(1) && pop)))
      begin
        out_data_o <= in_data_i;
      end
      else if (pop)
      begin
        out_data_o <= mem_q[next_ptr(rd_ptr_q)];
      end
    end
  end

endmodule

// [core/host_fifo_ports.sv]
/*
 * Host-facing FIFO ports: receive status, receive data, transmit status and transmit
 * data, plus a small control, event, latch and level register set on the same bus.
 * Assumes the host issues one-cycle read or write strobes synchronous to sys_clk_i,
 * and that the MAC side uses valid/ready streams on the same clock.
 */
// Function
// - Writes to read-only registers change nothing in the device.
// - Reads of write-only locations return all zero bits.
// - Write-one-clear bits read back live; one clears, zero leaves them.
// - Read-to-clear bits return to zero when their register is read.
// - Latched-low and latched-high bits hold until their register is read.
// - Software-reset-immune fields survive soft reset; only system reset sets them.
// - System, software or power-on reset loads every register with its default; soft reset leaves the scratch field as last written.
// - Four host FIFOs exist: receive status, receive data, transmit status, transmit data.
// - Receive status and both data FIFO sizes are adjustable by control inputs.
// - Receive status and receive data FIFOs are read-only; host writes do nothing.
// - Receive status pop address returns the head and removes it.
// - Receive status peek address returns the head and keeps it.
// - Every receive data port read returns the head word and advances; 16-bit hosts get one half per read and advance on the second.
// - Receive data port answers at eight words, or sixteen halfwords, of aliases.
// - Transmit status pop address returns the head and removes it.
// - Transmit status peek address returns the head without removing it.
// - Transmit data port is write-only: writes push, reads return zero.
// - Transmit data port accepts writes at any address of its alias block.
`timescale 1ns/100ps
module host_fifo_ports #(
  parameter int DEPTH = host_fifo_pkg::FIFO_DEPTH,
  parameter int LVL_W = $clog2(DEPTH + 1)
) (
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       ce_i,
  input  wire logic                       bus16_i,
  input  wire host_fifo_pkg::host_req_t   host_req_i,
  output logic [host_fifo_pkg::DATA_W-1:0] host_rdata_o,
  output logic                            host_rvalid_o,
  input  wire logic [LVL_W-1:0]           rx_sts_limit_i,
  input  wire logic [LVL_W-1:0]           rx_data_limit_i,
  input  wire logic [LVL_W-1:0]           tx_data_limit_i,
  input  wire logic [host_fifo_pkg::DATA_W-1:0] rx_data_i,
  input  wire logic                       rx_valid_i,
  output logic                            rx_ready_o,
  input  wire logic [host_fifo_pkg::DATA_W-1:0] rx_sts_i,
  input  wire logic                       rx_sts_valid_i,
  output logic                            rx_sts_ready_o,
  input  wire logic [host_fifo_pkg::DATA_W-1:0] tx_sts_i,
  input  wire logic                       tx_sts_valid_i,
  output logic                            tx_sts_ready_o,
  output logic [host_fifo_pkg::DATA_W-1:0] tx_data_o,
  output logic                            tx_valid_o,
  input  wire logic                       tx_ready_i,
  input  wire logic                       frame_drop_i,
  input  wire logic                       link_up_i
);
  localparam int DW = host_fifo_pkg::DATA_W;

  logic [DW-1:0]    rxs_head;
  logic [DW-1:0]    rxd_head;
  logic [DW-1:0]    txs_head;
  logic             rxs_valid;
  logic             rxd_valid;
  logic             txs_valid;
  logic             txd_ready;
  logic [LVL_W-1:0] rxs_lvl;
  logic [LVL_W-1:0] rxd_lvl;
  logic [LVL_W-1:0] txs_lvl;
  logic [LVL_W-1:0] txd_lvl;

  logic             soft_rst_q;
  logic             rx_flush_q;
  logic             tx_flush_q;
  logic [host_fifo_pkg::SCRATCH_W-1:0] scratch_q;
  logic [host_fifo_pkg::EV_W-1:0]      event_q;
  logic             lat_high_q;
  logic             lat_low_q;
  logic [host_fifo_pkg::DROP_W-1:0]    drop_q;
  logic             rx_half_q;
  logic             tx_half_q;
  logic [15:0]      tx_low_q;

  logic             any_rst;
  logic [7:0]       word_addr;
  logic [2:0]       block;
  logic             hit_rxd;
  logic             hit_txd;
  logic             rd_hi;
  logic [DW-1:0]    wmask;
  logic [DW-1:0]    wfull;
  logic [DW-1:0]    ctrl_word;
  logic [DW-1:0]    event_word;
  logic [DW-1:0]    latch_word;
  logic [DW-1:0]    level_word;
  logic [DW-1:0]    rd_word;
  logic             rxs_pop;
  logic             rxd_pop;
  logic             txs_pop;
  logic             rxd_take;
  logic             latch_read;
  logic [host_fifo_pkg::EV_W-1:0] ev_set;
  logic             txd_wr;
  logic             txd_push;
  logic [DW-1:0]    txd_word;
  logic             ctrl_wr;
  logic             event_wr;
  logic             rx_clear;
  logic             tx_clear;

  assign any_rst   = !rst_n_i || (ce_i && soft_rst_q);
  assign word_addr = {host_req_i.addr[7:2], 2'b00};
  assign block     = host_req_i.addr[7:host_fifo_pkg::ALIAS_SHIFT];
  assign hit_rxd   = (block == host_fifo_pkg::RX_DATA_BLOCK);
  assign hit_txd   = (block == host_fifo_pkg::TX_DATA_BLOCK);
  assign rx_clear  = soft_rst_q || rx_flush_q;
  assign tx_clear  = soft_rst_q || tx_flush_q;

  // In 16-bit mode a write lands in the half that the address selects.
  assign wmask = !bus16_i ? '1 :
                 (host_req_i.addr[1] ? host_fifo_pkg::MASK_HI16 : host_fifo_pkg::MASK_LO16);
  assign wfull = bus16_i ? {2{host_req_i.wdata[15:0]}} : host_req_i.wdata;

  assign ctrl_word  = (DW'(scratch_q) << host_fifo_pkg::CTRL_SCRATCH_LSB)
                    | (DW'(soft_rst_q) << host_fifo_pkg::CTRL_SOFT_RST_BIT)
                    | (DW'(rx_flush_q) << host_fifo_pkg::CTRL_RX_FLUSH_BIT)
                    | (DW'(tx_flush_q) << host_fifo_pkg::CTRL_TX_FLUSH_BIT);
  assign event_word = DW'(event_q);
  assign latch_word = (DW'(drop_q) << host_fifo_pkg::DROP_LSB)
                    | (DW'(lat_high_q) << host_fifo_pkg::LAT_HIGH_BIT)
                    | (DW'(lat_low_q) << host_fifo_pkg::LAT_LOW_BIT);
  assign level_word = (DW'(rxs_lvl) << host_fifo_pkg::LVL_RX_STS_LSB)
                    | (DW'(rxd_lvl) << host_fifo_pkg::LVL_RX_DATA_LSB)
                    | (DW'(txs_lvl) << host_fifo_pkg::LVL_TX_STS_LSB)
                    | (DW'(txd_lvl) << host_fifo_pkg::LVL_TX_DATA_LSB);

  // Read decode: pops happen in the strobe cycle, data is registered one cycle later.
  always_comb
  begin
    rd_word    = host_fifo_pkg::WORD_ZERO;
    rxs_pop    = 1'b0;
    rxd_pop    = 1'b0;
    txs_pop    = 1'b0;
    rxd_take   = 1'b0;
    latch_read = 1'b0;
    ev_set     = '0;
    rd_hi      = host_req_i.addr[1];
    if (host_req_i.rd)
    begin
      if (hit_rxd)
      begin
        rd_word  = rxd_head;
        rd_hi    = rx_half_q;
        rxd_take = !bus16_i || rx_half_q;
        rxd_pop  = rxd_take && rxd_valid;
        ev_set[host_fifo_pkg::EV_RX_UNDER_BIT] = rxd_take && !rxd_valid;
      end
      else if (hit_txd)
      begin
        rd_word = host_fifo_pkg::WORD_ZERO;
      end
      else if (word_addr == host_fifo_pkg::RX_STS_POP)
      begin
        rd_word = rxs_head;
        rxs_pop = (!bus16_i || host_req_i.addr[1]) && rxs_valid;
        ev_set[host_fifo_pkg::EV_STS_UNDER_BIT] = !rxs_valid;
      end
      else if (word_addr == host_fifo_pkg::RX_STS_PEEK)
      begin
        rd_word = rxs_head;
      end
      else if (word_addr == host_fifo_pkg::TX_STS_POP)
      begin
        rd_word = txs_head;
        txs_pop = (!bus16_i || host_req_i.addr[1]) && txs_valid;
        ev_set[host_fifo_pkg::EV_STS_UNDER_BIT] = !txs_valid;
      end
      else if (word_addr == host_fifo_pkg::TX_STS_PEEK)
      begin
        rd_word = txs_head;
      end
      else if (word_addr == host_fifo_pkg::CTRL_OFS)
      begin
        rd_word = ctrl_word;
      end
      else if (word_addr == host_fifo_pkg::EVENT_OFS)
      begin
        rd_word = event_word;
      end
      else if (word_addr == host_fifo_pkg::LATCH_OFS)
      begin
        rd_word    = latch_word;
        latch_read = !bus16_i || host_req_i.addr[1];
      end
      else if (word_addr == host_fifo_pkg::LEVEL_OFS)
      begin
        rd_word = level_word;
      end
      else
      begin
        rd_word = host_fifo_pkg::WORD_ZERO;
      end
    end
    if (txd_wr && !tx_half_q && !txd_ready)
    begin
      ev_set[host_fifo_pkg::EV_TX_OVR_BIT] = 1'b1;
    end
    else if (txd_wr && bus16_i && tx_half_q && !txd_ready)
    begin
      ev_set[host_fifo_pkg::EV_TX_OVR_BIT] = 1'b1;
    end
  end

  // Writes to the receive ports, status ports and the level register fall through
  // every decode below and therefore alter nothing.
  assign txd_wr   = host_req_i.wr && hit_txd;
  assign txd_push = txd_wr && (!bus16_i || tx_half_q);
  assign txd_word = bus16_i ? {host_req_i.wdata[15:0], tx_low_q} : host_req_i.wdata;
  assign ctrl_wr  = host_req_i.wr && !hit_rxd && !hit_txd
                    && (word_addr == host_fifo_pkg::CTRL_OFS);
  assign event_wr = host_req_i.wr && !hit_rxd && !hit_txd
                    && (word_addr == host_fifo_pkg::EVENT_OFS);

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      host_rdata_o  <= host_fifo_pkg::WORD_ZERO;
      host_rvalid_o <= 1'b0;
    end
    else if (ce_i)
    begin
      host_rvalid_o <= host_req_i.rd;
      if (host_req_i.rd)
      begin
        host_rdata_o <= !bus16_i ? rd_word :
                        (rd_hi ? {16'h0000, rd_word[31:16]} : {16'h0000, rd_word[15:0]});
      end
    end
  end

  // Self-clearing actions last exactly one cycle and then drop on their own.
  always_ff @(posedge sys_clk_i)
  begin
    if (any_rst)
    begin
      soft_rst_q <= 1'b0;
      rx_flush_q <= 1'b0;
      tx_flush_q <= 1'b0;
    end
    else if (ce_i)
    begin
      soft_rst_q <= ctrl_wr && wmask[host_fifo_pkg::CTRL_SOFT_RST_BIT]
                    && wfull[host_fifo_pkg::CTRL_SOFT_RST_BIT];
      rx_flush_q <= ctrl_wr && wmask[host_fifo_pkg::CTRL_RX_FLUSH_BIT]
                    && wfull[host_fifo_pkg::CTRL_RX_FLUSH_BIT];
      tx_flush_q <= ctrl_wr && wmask[host_fifo_pkg::CTRL_TX_FLUSH_BIT]
                    && wfull[host_fifo_pkg::CTRL_TX_FLUSH_BIT];
    end
  end

  // The scratch field only answers to the system reset, so software can leave a marker
  // that tells it afterwards whether the last reset was its own.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      scratch_q <= host_fifo_pkg::SCRATCH_RST;
    end
    else if (ce_i && ctrl_wr)
    begin
      scratch_q <= (scratch_q & ~wmask[15:8]) | (wfull[15:8] & wmask[15:8]);
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (any_rst)
    begin
      event_q <= host_fifo_pkg::EVENT_RST;
    end
    else if (ce_i)
    begin
      // A new event in the clearing cycle survives.
      event_q <= (event_q & ~(event_wr ? (wfull[2:0] & wmask[2:0]) : 3'h0)) | ev_set;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (any_rst)
    begin
      lat_high_q <= 1'b0;
      lat_low_q  <= 1'b1;
    end
    else if (ce_i)
    begin
      lat_high_q <= !rx_sts_ready_o || (lat_high_q && !latch_read);
      lat_low_q  <= link_up_i && (lat_low_q || latch_read);
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (any_rst)
    begin
      drop_q <= host_fifo_pkg::DROP_RST;
    end
    else if (ce_i)
    begin
      if (latch_read)
      begin
        drop_q <= frame_drop_i ? 16'h0001 : host_fifo_pkg::DROP_RST;
      end
      else if (frame_drop_i && drop_q != 16'hFFFF)
      begin
        drop_q <= drop_q + 16'h0001;
      end
    end
  end

  // Halfword pairing for 16-bit hosts: low half first, high half completes the word.
  always_ff @(posedge sys_clk_i)
  begin
    if (any_rst || (ce_i && !bus16_i))
    begin
      rx_half_q <= 1'b0;
      tx_half_q <= 1'b0;
      tx_low_q  <= 16'h0000;
    end
    else if (ce_i)
    begin
      if (host_req_i.rd && hit_rxd)
      begin
        rx_half_q <= !rx_half_q;
      end
      if (txd_wr)
      begin
        tx_half_q <= !tx_half_q;
        if (!tx_half_q)
        begin
          tx_low_q <= host_req_i.wdata[15:0];
        end
      end
    end
  end

  // One buffer per host-visible queue; the transmit status queue always uses full depth.
  fifo_buf #(.WIDTH(DW), .DEPTH(DEPTH), .LVL_W(LVL_W)) u_rx_sts (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .clear_i     (soft_rst_q),
    .limit_i     (rx_sts_limit_i),
    .in_data_i   (rx_sts_i),
    .in_valid_i  (rx_sts_valid_i),
    .in_ready_o  (rx_sts_ready_o),
    .out_data_o  (rxs_head),
    .out_valid_o (rxs_valid),
    .out_ready_i (rxs_pop),
    .level_o     (rxs_lvl)
  );

  fifo_buf #(.WIDTH(DW), .DEPTH(DEPTH), .LVL_W(LVL_W)) u_rx_data (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .clear_i     (rx_clear),
    .limit_i     (rx_data_limit_i),
    .in_data_i   (rx_data_i),
    .in_valid_i  (rx_valid_i),
    .in_ready_o  (rx_ready_o),
    .out_data_o  (rxd_head),
    .out_valid_o (rxd_valid),
    .out_ready_i (rxd_pop),
    .level_o     (rxd_lvl)
  );

  fifo_buf #(.WIDTH(DW), .DEPTH(DEPTH), .LVL_W(LVL_W)) u_tx_sts (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .clear_i     (soft_rst_q),
    .limit_i     (LVL_W'(DEPTH)),
    .in_data_i   (tx_sts_i),
    .in_valid_i  (tx_sts_valid_i),
    .in_ready_o  (tx_sts_ready_o),
    .out_data_o  (txs_head),
    .out_valid_o (txs_valid),
    .out_ready_i (txs_pop),
    .level_o     (txs_lvl)
  );

  // A host write into a full transmit queue is dropped and flagged, not stalled,
  // because the host bus has no wait signal.
  fifo_buf #(.WIDTH(DW), .DEPTH(DEPTH), .LVL_W(LVL_W)) u_tx_data (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .clear_i     (tx_clear),
    .limit_i     (tx_data_limit_i),
    .in_data_i   (txd_word),
    .in_valid_i  (txd_push),
    .in_ready_o  (txd_ready),
    .out_data_o  (tx_data_o),
    .out_valid_o (tx_valid_o),
    .out_ready_i (tx_ready_i),
    .level_o     (txd_lvl)
  );

endmodule

// [bench/host_fifo_ports_props.sv]
/* Checker for the host FIFO port block, bound to its top module.
   Assumes 32-bit host mode for the push check and a clock enable on the strobes. */
`timescale 1ns/100ps
module host_fifo_ports_props (
  input wire logic                             sys_clk_i,
  input wire logic                             rst_n_i,
  input wire logic                             ce_i,
  input wire logic                             bus16_i,
  input wire host_fifo_pkg::host_req_t         host_req_i,
  input wire logic [host_fifo_pkg::DATA_W-1:0] host_rdata_o,
  input wire logic                             host_rvalid_o,
  input wire logic                             rx_ready_o,
  input wire logic                             tx_sts_ready_o,
  input wire logic [host_fifo_pkg::DATA_W-1:0] tx_data_o,
  input wire logic                             tx_valid_o,
  input wire logic                             tx_ready_i
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic rd_t;
  logic wr_t;
  assign rd_t = ce_i && host_req_i.rd;
  assign wr_t = ce_i && host_req_i.wr;
  sequence soft_rst_s;
    wr_t && host_req_i.addr == host_fifo_pkg::CTRL_OFS && host_req_i.wdata[0];
  endsequence
  sequence tx_push_s;
    wr_t && !bus16_i && host_req_i.addr[7:5] == host_fifo_pkg::TX_DATA_BLOCK && !tx_valid_o;
  endsequence
  AST_RVALID_AFTER_RD:
    assert property (rd_t |=> host_rvalid_o)
    else $error("read strobe not answered next cycle");
  AST_NO_SPURIOUS_RVALID:
    assert property (host_rvalid_o |-> $past(rd_t))
    else $error("read answer without a strobe");
  AST_TX_READ_ZERO:
    assert property (rd_t && host_req_i.addr[7:5] == host_fifo_pkg::TX_DATA_BLOCK
      |=> host_rdata_o == host_fifo_pkg::WORD_ZERO) else $error("transmit port read not zero");
  AST_TX_PUSH:
    assert property (tx_push_s |=> tx_valid_o && tx_data_o == $past(host_req_i.wdata))
    else $error("transmit write not at stream head");
  AST_TX_HOLD:
    assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("transmit head changed while stalled");
  AST_SOFT_RST:
    assert property (soft_rst_s |=> !rx_ready_o && !tx_sts_ready_o ##1 !tx_valid_o)
    else $error("soft reset did not empty the buffers");
  AST_RESET_DEFAULTS:
    assert property ($rose(rst_n_i) |-> !tx_valid_o && !host_rvalid_o && host_rdata_o == 0)
    else $error("outputs not at reset defaults");
  AST_UNMAPPED_ZERO:
    assert property (rd_t && host_req_i.addr >= 8'h60 |=> host_rdata_o == 0)
    else $error("unmapped read not zero");
endmodule

// [bench/host_model.sv]
/* Host CPU model issuing one-cycle read and write strobes.
   Assumes the device answers each read with a pulse one cycle after the strobe. */
`timescale 1ns/100ps
module host_model (
  input  wire logic        sys_clk_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic        rvalid_i,
  output host_fifo_pkg::host_req_t req_o
);
  initial req_o = '0;
  // This host passes on whatever the bench asks, including random words to read-only registers and a read of unmapped 8'h80.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    req_o <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge sys_clk_i);
    req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic ok);
    @(posedge sys_clk_i);
    req_o <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
    @(posedge sys_clk_i);
    req_o.rd <= 1'b0;
    @(posedge sys_clk_i);
    ok = rvalid_i;
    d = rdata_i;
  endtask
endmodule

// [bench/host_fifo_ports_tb.sv]
/* Self-checking bench for the host FIFO port block with queue models.
   Assumes the host model and checker are compiled before this file. */
`timescale 1ns/100ps
module host_fifo_ports_tb;
  localparam int LIM = 4;
  logic        sys_clk_i, rst_n_i, tx_rdy, stall, drop, link, ce, b16;
  logic [31:0] sdat [3];
  logic [2:0]  sval;
  wire  [2:0]  srdy;
  wire  [31:0] rdata, tx_data;
  wire         rvalid, tx_valid;
  host_fifo_pkg::host_req_t req;
  logic [31:0] rxq[$], txq[$];
  int          fails, num_checks, cyc;
  int          seed = 64096;
  host_model u_host (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));
  host_fifo_ports u_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .bus16_i(b16), .host_req_i(req),
    .host_rdata_o(rdata), .host_rvalid_o(rvalid), .rx_sts_limit_i(4'h0),
    .rx_data_limit_i(4'(LIM)), .tx_data_limit_i(4'h0), .rx_data_i(sdat[0]),
    .rx_valid_i(sval[0]), .rx_ready_o(srdy[0]), .rx_sts_i(sdat[1]), .rx_sts_valid_i(sval[1]),
    .rx_sts_ready_o(srdy[1]), .tx_sts_i(sdat[2]), .tx_sts_valid_i(sval[2]),
    .tx_sts_ready_o(srdy[2]), .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_rdy),
    .frame_drop_i(drop), .link_up_i(link));
  task automatic print_verdict();
    if (fails == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic        ok;
    u_host.rd(a, d, ok);
    report(ok === 1'b1 ? d & m : ~e, e);
  endtask
  // An empty model queue yields the inverse so that a stray word never matches.
  task automatic chk_tx(input logic [31:0] d);
    report(d, txq.size() > 0 ? txq.pop_front() : ~d);
  endtask
  task automatic push(input int k, input logic [31:0] d);
    @(posedge sys_clk_i);
    sdat[k] <= d;
    sval[k] <= 1'b1;
    do @(posedge sys_clk_i); while (srdy[k] !== 1'b1);
    sval[k] <= 1'b0;
  endtask
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i)
  begin
    if (tx_valid === 1'b1 && tx_rdy === 1'b1 && ce === 1'b1) chk_tx(tx_data);
    tx_rdy <= !stall & $random(seed);
    // The clock enable only wanders while the transmit side drains and no host task runs.
    ce <= stall | $random(seed);
  end
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      print_verdict();
    end
  end
  initial
  begin
    logic [31:0] a, b;
    logic [7:0]  base;
    rst_n_i = 1'b0; tx_rdy = 1'b0; stall = 1'b1; drop = 1'b0; link = 1'b1;
    sval = 3'h0;
    ce = 1'b1;
    b16 = 1'b0;
    sdat = '{default: 32'h0};
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 4; i++) if (i != 2) chk_rd(8'h50 + 8'(4 * i), '1, 32'h0);
    chk_rd(host_fifo_pkg::LATCH_OFS, 32'h2, 32'h2);
    // Fill past the run-time limit so the refusal point is seen.
    @(posedge sys_clk_i);
    sval[0] <= 1'b1;
    sdat[0] <= $random(seed);
    repeat (12)
    begin
      @(posedge sys_clk_i);
      if (srdy[0] === 1'b1)
      begin
        rxq.push_back(sdat[0]);
        sdat[0] <= $random(seed);
      end
    end
    sval[0] <= 1'b0;
    chk_rd(host_fifo_pkg::LEVEL_OFS, 32'hF00, 32'(LIM) << 8);
    for (int i = 0; i < LIM; i++) chk_rd(8'h1C - 8'(8 * i), '1, rxq.pop_front());
    chk_rd(8'h00, 32'h0, 32'h0);
    chk_rd(host_fifo_pkg::EVENT_OFS, 32'h2, 32'h2);
    u_host.wr(host_fifo_pkg::EVENT_OFS, 32'h0);
    chk_rd(host_fifo_pkg::EVENT_OFS, 32'h2, 32'h2);
    u_host.wr(host_fifo_pkg::EVENT_OFS, 32'h2);
    chk_rd(host_fifo_pkg::EVENT_OFS, 32'h2, 32'h0);
    for (int k = 1; k < 3; k++)
    begin
      base = k == 1 ? host_fifo_pkg::RX_STS_POP : host_fifo_pkg::TX_STS_POP;
      a = $random(seed);
      b = $random(seed);
      push(k, a);
      push(k, b);
      u_host.wr(base, ~a);
      chk_rd(host_fifo_pkg::LEVEL_OFS, 32'hF << (16 * (k - 1)), 32'h2 << (16 * (k - 1)));
      u_host.wr(host_fifo_pkg::LEVEL_OFS, a);
      chk_rd(host_fifo_pkg::LEVEL_OFS, 32'hF << (16 * (k - 1)), 32'h2 << (16 * (k - 1)));
      chk_rd(base + 8'h4, '1, a);
      chk_rd(base, '1, a);
      chk_rd(base + 8'h4, '1, b);
      chk_rd(base, '1, b);
    end
    // The ninth write meets a full buffer and must be dropped, not queued.
    for (int i = 0; i < 9; i++)
    begin
      a = $random(seed);
      u_host.wr(8'h20 + 8'(4 * (i % 8)), a);
      if (i < 8) txq.push_back(a);
    end
    chk_rd(8'h3C, '1, 32'h0);
    chk_rd(host_fifo_pkg::EVENT_OFS, 32'h1, 32'h1);
    u_host.wr(host_fifo_pkg::EVENT_OFS, 32'h1);
    stall <= 1'b0;
    for (int n = 0; n < 300 && txq.size() > 0; n++) @(posedge sys_clk_i);
    report(txq.size(), 32'h0);
    stall <= 1'b1;
    repeat (3)
    begin
      @(posedge sys_clk_i);
      drop <= 1'b1;
      link <= 1'b0;
      @(posedge sys_clk_i);
      drop <= 1'b0;
      link <= 1'b1;
    end
    chk_rd(host_fifo_pkg::LATCH_OFS, 32'hFFFF0002, 32'h00030000);
    chk_rd(host_fifo_pkg::LATCH_OFS, 32'hFFFF0000, 32'h0);
    chk_rd(8'h80, '1, 32'h0);
    push(0, a);
    b16 <= 1'b1;
    chk_rd(8'h02, '1, a & 32'h0000FFFF);
    chk_rd(8'h1E, '1, a >> 16);
    push(1, a);
    u_host.wr(host_fifo_pkg::CTRL_OFS, 32'h0000A501);
    chk_rd(host_fifo_pkg::CTRL_OFS, '1, 32'h0000A500);
    chk_rd(host_fifo_pkg::LEVEL_OFS, '1, 32'h0);
    print_verdict();
  end
endmodule
bind host_fifo_ports host_fifo_ports_props u_props (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .bus16_i(bus16_i),
  .host_req_i(host_req_i), .host_rdata_o(host_rdata_o), .host_rvalid_o(host_rvalid_o),
  .rx_ready_o(rx_ready_o), .tx_sts_ready_o(tx_sts_ready_o), .tx_data_o(tx_data_o),
  .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i));
